// ==== verilog/eeprom_params.svh ====
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH
// ----------------------------------------
// command byte layout
// ----------------------------------------
`define PREAMBLE_MSB   7
`define PREAMBLE_LSB   4
`define SELECT_MSB     3
`define SELECT_LSB     1
`define RW_BIT         0
`define MEM_PREAMBLE   4'hA
`define PERM_PREAMBLE  4'h6
`define REV_PREAMBLE   4'h7
`define QUERY_FILL     8'hFF
`define MEM_DEPTH      256
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS  50
`define SCL_PERIOD_NS  10000
`define QUARTER_CYC    (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))
`define FIFO_DEPTH     8
// ----------------------------------------
// controller register map and fields
// ----------------------------------------
`define REG_CONTROL    4'h0
`define REG_TARGET     4'h4
`define REG_STATUS     4'h8
`define REG_RX_DATA    4'hC
`define CTL_OP_LSB     0
`define CTL_GO_BIT     4
`define CTL_COUNT_LSB  8
`define TGT_SELECT_LSB 8
`define STS_BUSY_BIT   0
`define STS_NACK_BIT   1
`define STS_VALID_BIT  2
`define STS_DONE_BIT   3
`define RXD_VALID_BIT  8
`endif

// ==== verilog/eeprom_pkg.sv ====
`default_nettype none
package eeprom_pkg;
   typedef enum logic [1:0] {OP_CUR_READ, OP_RAND_READ, OP_PERM_QUERY, OP_REV_QUERY} host_op_t;
   typedef enum {T_IDLE, T_ADDR, T_ACK_ADDR, T_WORD, T_ACK_WORD, T_DATA_IN, T_TX, T_RX_ACK}
      target_state_t;
   typedef enum {H_IDLE, H_START, H_TXBIT, H_TXACK, H_RXBIT, H_RXACK, H_STOP} host_state_t;
endpackage
`default_nettype wire

// ==== verilog/eeprom_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// open-drain two-wire link; an enable pulls its wire low
interface eeprom_link_if;
   logic host_scl_oe;
   logic host_sda_oe;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // wired-and with pull-ups
   assign scl = ~host_scl_oe;
   assign sda = ~(host_sda_oe | dev_sda_oe);
   modport host (output host_scl_oe, output host_sda_oe, input scl, input sda);
   modport target (output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// ==== verilog/eeprom_read_target.sv ====
// Operation
// - host opens reads like writes, direction one
// - counter holds last accessed location plus one
// - counter survives between transactions
// - counter wraps from last to first byte
// - after read address ack, send current byte
// - host ends current read: nack, stop
// - random read starts with dummy address write
// - host repeats start, sends read address
// - random read sends byte at loaded address
// - sequential read continues while host acknowledges
// - increment address, send next byte each time
// - sequential read wraps without interruption
// - nack plus stop ends read, line released
// - query byte: 0110, select pins, one (the reversible query uses 0111 here)
// - permanent query acks only when flag clear
// - reversible query acks only when flag clear
// - data after acked query is don't care
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_params.svh"
module eeprom_read_target
   import eeprom_pkg::*;
#(
   parameter int MEM_DEPTH = `MEM_DEPTH
)
(
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   eeprom_link_if.target   link,
   input  wire logic [2:0] address_select_pins_i,
   input  wire logic       permanent_protect_flag_i,
   input  wire logic       reversible_protect_flag_i,
   output logic [7:0]      current_addr_o
);
   // ----------------------------------------
   // line sampling and bus conditions
   // ----------------------------------------
   logic          scl_q;
   logic          sda_q;
   logic          scl_rise;
   logic          scl_fall;
   logic          start_seen;
   logic          stop_seen;
   target_state_t state;
   logic [3:0]    bit_cnt;
   logic [7:0]    shift;
   logic [7:0]    word_addr;
   logic          is_read;
   logic          is_query;
   logic          sda_oe;
   logic [7:0]    tx_byte;
   logic [7:0]    mem [MEM_DEPTH];

   // previous line levels; inputs are already synchronous
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= link.scl;
         sda_q <= link.sda;
      end
   end

   assign scl_rise   = link.scl & ~scl_q;
   assign scl_fall   = ~link.scl & scl_q;
   assign start_seen = link.scl & scl_q & sda_q & ~link.sda;
   assign stop_seen  = link.scl & scl_q & ~sda_q & link.sda;

   // ----------------------------------------
   // storage array
   // ----------------------------------------
   // read-only here: each byte resets to its own address so tests see known data
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < MEM_DEPTH; i++)
         begin
            mem[i] <= 8'(i);
         end
      end
   end

   // query reads return filler, the host discards it
   assign tx_byte = is_query ? `QUERY_FILL : mem[word_addr];

   // decide whether an address byte is for us and whether to acknowledge it
   function automatic logic addr_ack(input logic [7:0] b, input logic [2:0] pins,
                                     input logic pflag, input logic rflag);
      logic ok;
      ok = 1'b0;
      if (b[`SELECT_MSB:`SELECT_LSB] == pins)
      begin
         case (b[`PREAMBLE_MSB:`PREAMBLE_LSB])
            `MEM_PREAMBLE:  ok = 1'b1;
            `PERM_PREAMBLE: ok = b[`RW_BIT] & ~pflag;
            `REV_PREAMBLE:  ok = b[`RW_BIT] & ~rflag;
            default:        ok = 1'b0;
         endcase
      end
      return ok;
   endfunction

   // ----------------------------------------
   // protocol engine
   // ----------------------------------------
   // word_addr has no reset path besides rst_n_i, so it outlives every transaction
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state     <= T_IDLE;
         bit_cnt   <= 4'h0;
         shift     <= 8'h00;
         word_addr <= 8'h00;
         is_read   <= 1'b0;
         is_query  <= 1'b0;
         sda_oe    <= 1'b0;
      end
      else if (start_seen)
      begin
         // a repeated start may abort anything, even a byte in flight
         state   <= T_ADDR;
         bit_cnt <= 4'h0;
         sda_oe  <= 1'b0;
      end
      else if (stop_seen)
      begin
         state  <= T_IDLE;
         sda_oe <= 1'b0;
      end
      else
      begin
         case (state)
            T_IDLE:
            begin
               sda_oe <= 1'b0;
            end
            T_ADDR, T_WORD, T_DATA_IN:
            begin
               if (scl_rise)
               begin
                  shift   <= {shift[6:0], link.sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               else if (scl_fall && bit_cnt == 4'h8)
               begin
                  bit_cnt <= 4'h0;
                  if (state == T_ADDR)
                  begin
                     is_read  <= shift[`RW_BIT];
                     is_query <= shift[`PREAMBLE_MSB:`PREAMBLE_LSB] != `MEM_PREAMBLE;
                     if (addr_ack(shift, address_select_pins_i, permanent_protect_flag_i,
                                  reversible_protect_flag_i))
                     begin
                        sda_oe <= 1'b1;
                        state  <= T_ACK_ADDR;
                     end
                     else
                     begin
                        state <= T_IDLE;
                     end
                  end
                  else
                  begin
                     // write data is acknowledged but not stored in this path
                     if (state == T_WORD)
                     begin
                        word_addr <= shift;
                     end
                     sda_oe <= 1'b1;
                     state  <= T_ACK_WORD;
                  end
               end
            end
            T_ACK_ADDR:
            begin
               if (scl_fall)
               begin
                  if (is_read)
                  begin
                     shift   <= {tx_byte[6:0], 1'b0};
                     sda_oe  <= ~tx_byte[7];
                     bit_cnt <= 4'h1;
                     state   <= T_TX;
                     if (!is_query)
                     begin
                        word_addr <= word_addr + 8'h01;
                     end
                  end
                  else if (is_query)
                  begin
                     sda_oe <= 1'b0;
                     state  <= T_IDLE;
                  end
                  else
                  begin
                     sda_oe <= 1'b0;
                     state  <= T_WORD;
                  end
               end
            end
            T_ACK_WORD:
            begin
               if (scl_fall)
               begin
                  sda_oe <= 1'b0;
                  state  <= T_DATA_IN;
               end
            end
            T_TX:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt == 4'h8)
                  begin
                     sda_oe <= 1'b0;
                     state  <= T_RX_ACK;
                  end
                  else
                  begin
                     sda_oe  <= ~shift[7];
                     shift   <= {shift[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            T_RX_ACK:
            begin
               if (scl_rise)
               begin
                  is_read <= ~link.sda; // host ack remembered until the fall
               end
               else if (scl_fall)
               begin
                  if (is_read)
                  begin
                     shift   <= {tx_byte[6:0], 1'b0};
                     sda_oe  <= ~tx_byte[7];
                     bit_cnt <= 4'h1;
                     state   <= T_TX;
                     if (!is_query)
                     begin
                        word_addr <= word_addr + 8'h01;
                     end
                  end
                  else
                  begin
                     state <= T_IDLE;
                  end
               end
            end
            default:
            begin
               state  <= T_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   assign link.dev_sda_oe = sda_oe;

   // counter is visible to the user side for observation
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         current_addr_o <= 8'h00;
      end
      else
      begin
         current_addr_o <= word_addr;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/eeprom_read_host.sv ====
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_params.svh"
module eeprom_rx_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = `FIFO_DEPTH
)
(
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready_o  = count != (AW+1)'(DEPTH);
   assign out_valid_o = count != '0;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = store[rd_ptr];

   // pointers wrap at the power-of-two depth
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
         rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
         count  <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (push)
      begin
         store[wr_ptr] <= in_data_i;
      end
   end
endmodule

module eeprom_read_host
   import eeprom_pkg::*;
#(
   parameter int QUARTER_CYC = `QUARTER_CYC
)
(
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   eeprom_link_if.host      link,
   input  wire logic [3:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o
);
   // ----------------------------------------
   // registers and bit timing
   // ----------------------------------------
   host_state_t state;
   host_op_t    op;
   logic [15:0] div_cnt;
   logic        tick;
   logic        advance;
   logic [1:0]  q;
   logic [2:0]  bit_cnt;
   logic [1:0]  stage;
   logic [7:0]  tx_sh;
   logic [7:0]  rx_sh;
   logic [7:0]  remaining;
   logic [7:0]  word_addr;
   logic [2:0]  select;
   logic        push_needed;
   logic        nack;
   logic        done;
   logic        scl_oe;
   logic        sda_oe;
   logic        go;
   logic        fifo_ready;
   logic        fifo_valid;
   logic        pop;
   logic [7:0]  fifo_data;

   assign go      = wr_i && addr_i == `REG_CONTROL && wdata_i[`CTL_GO_BIT] && state == H_IDLE;
   assign pop     = rd_i && addr_i == `REG_RX_DATA && fifo_valid;
   assign tick    = div_cnt == 16'(QUARTER_CYC - 1);
   // a full fifo holds scl low between bytes, stalling the target
   assign advance = tick && !push_needed;

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         div_cnt <= 16'h0000;
      end
      else
      begin
         div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
      end
   end

   // target configuration register
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         word_addr <= 8'h00;
         select    <= 3'h0;
      end
      else if (wr_i && addr_i == `REG_TARGET)
      begin
         word_addr <= wdata_i[7:0];
         select    <= wdata_i[`TGT_SELECT_LSB+:3];
      end
   end

   // ----------------------------------------
   // transfer sequencer, four quarters per bit
   // ----------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state <= H_IDLE;
         op <= OP_CUR_READ;
         q <= 2'h0;
         bit_cnt <= 3'h0;
         stage <= 2'h0;
         tx_sh <= 8'h00;
         rx_sh <= 8'h00;
         remaining <= 8'h00;
         push_needed <= 1'b0;
         nack <= 1'b0;
         done <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end
      else
      begin
         if (push_needed && fifo_ready)
         begin
            push_needed <= 1'b0;
         end
         if (go)
         begin
            op <= host_op_t'(wdata_i[`CTL_OP_LSB+:2]);
            remaining <= (wdata_i[`CTL_COUNT_LSB+:8] == 8'h00 || wdata_i[1]) ? 8'h01
                         : wdata_i[`CTL_COUNT_LSB+:8];
            case (host_op_t'(wdata_i[`CTL_OP_LSB+:2]))
               OP_RAND_READ:  tx_sh <= {`MEM_PREAMBLE, select, 1'b0};
               OP_PERM_QUERY: tx_sh <= {`PERM_PREAMBLE, select, 1'b1};
               OP_REV_QUERY:  tx_sh <= {`REV_PREAMBLE, select, 1'b1};
               default:       tx_sh <= {`MEM_PREAMBLE, select, 1'b1};
            endcase
            stage <= 2'h0;
            nack <= 1'b0;
            done <= 1'b0;
            q <= 2'h0;
            state <= H_START;
         end
         else if (advance && state != H_IDLE)
         begin
            q <= q + 2'h1;
            case (state)
               H_START:
               begin
                  // a repeated start keeps scl low through q0 so the low phase is not cut short
                  sda_oe <= q == 2'h2 || q == 2'h3;
                  scl_oe <= q == 2'h3 || (q == 2'h0 && scl_oe);
                  bit_cnt <= 3'h7;
                  state <= q == 2'h3 ? H_TXBIT : H_START;
               end
               H_TXBIT, H_RXBIT:
               begin
                  if (q == 2'h0)
                     sda_oe <= state == H_TXBIT && !tx_sh[7];
                  scl_oe <= q == 2'h0 || q == 2'h3;
                  if (q == 2'h2)
                     rx_sh <= {rx_sh[6:0], link.sda};
                  if (q == 2'h3)
                  begin
                     tx_sh <= {tx_sh[6:0], 1'b0};
                     bit_cnt <= bit_cnt - 3'h1;
                     if (bit_cnt == 3'h0)
                     begin
                        push_needed <= state == H_RXBIT && op[1] == 1'b0;
                        state <= state == H_TXBIT ? H_TXACK : H_RXACK;
                     end
                  end
               end
               H_TXACK:
               begin
                  sda_oe <= 1'b0;
                  scl_oe <= q == 2'h0 || q == 2'h3;
                  if (q == 2'h2)
                     nack <= link.sda;
                  if (q == 2'h3)
                  begin
                     bit_cnt <= 3'h7;
                     if (nack)
                        state <= H_STOP;
                     else if (op == OP_RAND_READ && stage == 2'h0)
                     begin
                        tx_sh <= word_addr;
                        stage <= 2'h1;
                        state <= H_TXBIT;
                     end
                     else if (op == OP_RAND_READ && stage == 2'h1)
                     begin
                        tx_sh <= {`MEM_PREAMBLE, select, 1'b1};
                        stage <= 2'h2;
                        state <= H_START;
                     end
                     else
                        state <= H_RXBIT;
                  end
               end
               H_RXACK:
               begin
                  sda_oe <= remaining > 8'h01;
                  scl_oe <= q == 2'h0 || q == 2'h3;
                  if (q == 2'h3)
                  begin
                     bit_cnt <= 3'h7;
                     remaining <= remaining - 8'h01;
                     state <= remaining > 8'h01 ? H_RXBIT : H_STOP;
                  end
               end
               H_STOP:
               begin
                  sda_oe <= q != 2'h2 && q != 2'h3;
                  scl_oe <= q == 2'h0;
                  if (q == 2'h3)
                  begin
                     done <= 1'b1;
                     state <= H_IDLE;
                  end
               end
               default:
                  state <= H_IDLE;
            endcase
         end
      end
   end

   assign link.host_scl_oe = scl_oe;
   assign link.host_sda_oe = sda_oe;

   eeprom_rx_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) rx_fifo (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (push_needed),
      .in_ready_o  (fifo_ready),
      .in_data_i   (rx_sh),
      .out_valid_o (fifo_valid),
      .out_ready_i (pop),
      .out_data_o  (fifo_data)
   );

   // ----------------------------------------
   // register read port, data one cycle later
   // ----------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_o <= 32'h0000_0000;
      else if (rd_i && addr_i == `REG_STATUS)
         rdata_o <= {28'h0, done, fifo_valid, nack, state != H_IDLE};
      else if (rd_i && addr_i == `REG_RX_DATA)
         rdata_o <= {23'h0, fifo_valid, fifo_data};
      else if (rd_i && addr_i == `REG_TARGET)
         rdata_o <= {21'h0, select, word_addr};
      else
         rdata_o <= 32'h0000_0000;
   end
endmodule
`default_nettype wire

// ==== dv/eeprom_read_path_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module eeprom_read_path_monitor
#(
   parameter int QUARTER_CYC = 2
)
(
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic host_scl_oe,
   input  wire logic host_sda_oe,
   input  wire logic dev_sda_oe,
   input  wire logic scl,
   input  wire logic sda
);
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   int lo_run;
   // length of the clock-low phase; stretching only lengthens it, so a minimum is checked
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         lo_run <= 0;
      else
         lo_run <= scl ? 0 : lo_run + 1;
   end
   // ----------------------------------------
   // link properties
   // ----------------------------------------
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_start;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence s_stop;
      scl && $past(scl) && $rose(sda);
   endsequence
   property p_idle_after_reset;
      $rose(rst_n_i) |-> !dev_sda_oe && !host_sda_oe && !host_scl_oe;
   endproperty
   property p_dev_stable_high;
      scl && $past(scl) |-> $stable(dev_sda_oe);
   endproperty
   property p_dev_after_fall;
      $fell(scl) |-> $stable(dev_sda_oe);
   endproperty
   property p_no_contend;
      // both ends may pull low together while scl is low as the bit hands over
      scl |-> !(dev_sda_oe && host_sda_oe);
   endproperty
   property p_start_host;
      s_start |-> host_sda_oe;
   endproperty
   property p_stop_release;
      s_stop |=> !dev_sda_oe [*4];
   endproperty
   property p_stop_idle;
      s_stop |=> (!host_scl_oe && !host_sda_oe) [*4];
   endproperty
   property p_scl_low_min;
      $rose(scl) |-> lo_run >= 2 * QUARTER_CYC;
   endproperty
   a_idle_after_reset: assert property (p_idle_after_reset)
      else $error("link not idle after reset");
   a_dev_stable_high: assert property (p_dev_stable_high)
      else $error("target changed data while clock high");
   a_dev_after_fall: assert property (p_dev_after_fall)
      else $error("target changed data on the clock fall sample");
   a_no_contend: assert property (p_no_contend)
      else $error("both ends pull the data line");
   a_start_host: assert property (p_start_host)
      else $error("start not made by host");
   a_stop_release: assert property (p_stop_release)
      else $error("target holds data line after stop");
   a_stop_idle: assert property (p_stop_idle)
      else $error("host not idle after stop");
   a_scl_low_min: assert property (p_scl_low_min)
      else $error("clock low phase too short");
endmodule
`default_nettype wire

// ==== dv/eeprom_serial_read_path_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_params.svh"
module eeprom_serial_read_path_tb
   import eeprom_pkg::*;
;
   typedef struct {host_op_t op; logic [7:0] w; logic [2:0] s; int n; logic [1:0] fl;
                   logic [7:0] f; logic nk;} row_t;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        wr_i  = 1'b0;
   logic        rd_i  = 1'b0;
   logic        pf    = 1'b0;
   logic        rf    = 1'b0;
   logic [2:0]  pins  = 3'h5;
   logic [3:0]  addr  = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [7:0]  ca;
   logic [7:0]  ca_exp = 8'h00;
   int          n_errors = 0;
   int          n_compared = 0;
   // op, word, select, bytes, flags {perm,rev}, first byte, nack
   row_t rows [10] = '{
      '{OP_RAND_READ,  8'h10, 3'h5, 1, 2'h0, 8'h10, 1'b0},
      '{OP_CUR_READ,   8'h00, 3'h5, 1, 2'h0, 8'h11, 1'b0},
      '{OP_RAND_READ,  8'hFE, 3'h5, 4, 2'h0, 8'hFE, 1'b0},
      '{OP_CUR_READ,   8'h00, 3'h5, 2, 2'h0, 8'h02, 1'b0},
      '{OP_PERM_QUERY, 8'h00, 3'h5, 0, 2'h1, 8'h00, 1'b0},
      '{OP_PERM_QUERY, 8'h00, 3'h5, 0, 2'h2, 8'h00, 1'b1},
      '{OP_REV_QUERY,  8'h00, 3'h5, 0, 2'h2, 8'h00, 1'b0},
      '{OP_REV_QUERY,  8'h00, 3'h5, 0, 2'h1, 8'h00, 1'b1},
      '{OP_RAND_READ,  8'h40, 3'h2, 0, 2'h0, 8'h00, 1'b1},
      '{OP_CUR_READ,   8'h00, 3'h5, 1, 2'h0, 8'h04, 1'b0}};
   always #25 clock = ~clock;
   // ----------------------------------------
   // the two ends and the checker
   // ----------------------------------------
   eeprom_link_if link ();
   eeprom_read_target i_eeprom_read_target (.clock_i(clock), .rst_n_i(rst_n), .link(link),
      .address_select_pins_i(pins), .permanent_protect_flag_i(pf),
      .reversible_protect_flag_i(rf), .current_addr_o(ca));
   eeprom_read_host #(.QUARTER_CYC(2)) i_eeprom_read_host (.clock_i(clock), .rst_n_i(rst_n),
      .link(link), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata));
   eeprom_read_path_monitor #(.QUARTER_CYC(2)) i_eeprom_read_path_monitor (.clock_i(clock),
      .rst_n_i(rst_n), .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
      .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr_i  <= 1'b1;
      @(posedge clock);
      wr_i  <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd_i <= 1'b1;
      @(posedge clock);
      rd_i <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic go(input row_t r);
      logic [31:0] d;
      @(posedge clock);
      pf <= r.fl[1];
      rf <= r.fl[0];
      wr(`REG_TARGET, {21'h0, r.s, r.w});
      rd(`REG_TARGET, d);
      chk(d, {21'h0, r.s, r.w});
      wr(`REG_CONTROL, {16'h0, 8'(r.n), 3'h0, 1'b1, 2'h0, r.op});
   endtask
   // hold keeps the buffer undrained so it fills and the host has to stretch the clock
   task automatic run(input row_t r, input int hold);
      int k;
      logic [31:0] d;
      logic [31:0] st;
      k = 0;
      go(r);
      repeat (hold) @(posedge clock);
      if (hold > 0)
         chk(32'(link.scl), 32'h0);
      for (int i = 0; i < 5000; i++)
      begin
         rd(`REG_RX_DATA, d);
         if (d[8] === 1'b1)
         begin
            chk(32'(d[7:0]), 32'(8'(r.f + k)));
            k++;
         end
         rd(`REG_STATUS, st);
         if (st[3] === 1'b1 && st[2] === 1'b0)
            break;
      end
      if (r.n > 0)
         ca_exp = 8'(r.f + r.n);
      chk(32'(k), 32'(r.n));
      chk(32'(st[1:0]), 32'({r.nk, 1'b0}));
      chk(32'(ca), 32'(ca_exp));
   endtask
   task automatic end_of_test;
      $display("compared=%0d mismatches=%0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------
   // sequence of tests
   // ----------------------------------------
   initial
   begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      #1 chk(32'(ca), 32'h0);
      chk(32'({link.dev_sda_oe, link.host_sda_oe, link.host_scl_oe}), 32'h0);
      foreach (rows[i])
      begin
         run(rows[i], 0);
         $display("row %0d done", i);
      end
      run('{OP_RAND_READ, 8'h20, 3'h5, 12, 2'h0, 8'h20, 1'b0}, 3000);
      $display("buffer fill done");
      go('{OP_RAND_READ, 8'h30, 3'h5, 3, 2'h0, 8'h30, 1'b0});
      repeat (200) @(posedge clock);
      rst_n <= 1'b0;
      @(posedge clock);
      rst_n <= 1'b1;
      ca_exp = 8'h00;
      #1 chk(32'(link.dev_sda_oe), 32'h0);
      run('{OP_CUR_READ, 8'h00, 3'h5, 1, 2'h0, 8'h00, 1'b0}, 0);
      $display("mid-run reset done");
      end_of_test;
   end
   // the whole run is about 5700 cycles; this limit of 60000 cycles leaves ample margin
   initial
   begin
      #(60000 * 50);
      n_errors++;
      end_of_test;
   end
endmodule
`default_nettype wire
